// ### testbench/abod_datapath_assertions.sv
// Port checks for the add and bit-op datapath.
// Assumes one clock; bound to every datapath instance.
`timescale 1ns/100ps
module abod_datapath_assertions (
    input wire logic                   clk_sys_in,
    input wire logic                   rst_b_in,
    input wire logic                   instr_valid_in,
    input wire abod_pkg::abod_instr_s  instr_in,
    input wire logic [7:0]             reg_rd_data_in,
    input wire abod_pkg::abod_reg_wr_s reg_wr_out,
    input wire logic [7:0]             acc_out,
    input wire abod_pkg::abod_flags_s  flags_out,
    input wire logic                   done_out
);
    import abod_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    abod_op_e   op;
    logic [7:0] b, n, m;
    logic [8:0] s;
    logic       h, z;
    assign op = instr_valid_in ? instr_in.op : ABOD_OP_NONE;
    assign b = op inside {ABOD_OP_ADD_LITERAL_TO_ACC, ABOD_OP_AND_LITERAL_WITH_ACC}
        ? instr_in.literal : reg_rd_data_in;
    assign s = {1'b0, acc_out} + {1'b0, b};
    assign h = s[4] ^ acc_out[4] ^ b[4];
    assign z = s[7:0] == 8'h00;
    assign n = acc_out & b;
    assign m = 8'h01 << instr_in.bit_idx;
    sequence s_wr; reg_wr_out.wr_en && $stable(flags_out) && $stable(acc_out); endsequence
    property p_lit; op == ABOD_OP_ADD_LITERAL_TO_ACC |=> {flags_out.carry, acc_out} == $past(s); endproperty
    a_lit: assert property (p_lit) else $error("literal add wrong");
    property p_fl; op inside {ABOD_OP_ADD_LITERAL_TO_ACC, ABOD_OP_ADD_ACC_TO_REG}
        |=> flags_out.half_carry_flag == $past(h) && flags_out.zero == $past(z); endproperty
    a_fl: assert property (p_fl) else $error("add flags wrong");
    property p_add; op == ABOD_OP_ADD_ACC_TO_REG && instr_in.dest_sel == DEST_REG
        |=> reg_wr_out.wr_en && {flags_out.carry, reg_wr_out.data} == $past(s) && $stable(acc_out); endproperty
    a_add: assert property (p_add) else $error("register add wrong");
    property p_and; op == ABOD_OP_AND_ACC_WITH_REG && instr_in.dest_sel == DEST_ACC
        |=> acc_out == $past(n) && !reg_wr_out.wr_en; endproperty
    a_and: assert property (p_and) else $error("register and wrong");
    property p_andz; op inside {ABOD_OP_AND_ACC_WITH_REG, ABOD_OP_AND_LITERAL_WITH_ACC} |=> flags_out.zero
        == ($past(n) == 8'h00) && $stable(flags_out.carry) && $stable(flags_out.half_carry_flag); endproperty
    a_andz: assert property (p_andz) else $error("and flags wrong");
    property p_clr; op == ABOD_OP_BIT_CLEAR_IN_REG
        |=> s_wr ##0 reg_wr_out.data == ($past(reg_rd_data_in) & ~$past(m)); endproperty
    a_clr: assert property (p_clr) else $error("bit clear wrong");
    property p_set; op == ABOD_OP_BIT_SET_IN_REG
        |=> s_wr ##0 reg_wr_out.data == ($past(reg_rd_data_in) | $past(m)); endproperty
    a_set: assert property (p_set) else $error("bit set wrong");
    property p_acc; op == ABOD_OP_ADD_ACC_TO_REG && instr_in.dest_sel == DEST_ACC
        |=> acc_out == $past(s[7:0]) && !reg_wr_out.wr_en && done_out; endproperty
    a_acc: assert property (p_acc) else $error("add to acc wrong");
endmodule
bind abod_datapath abod_datapath_assertions abod_datapath_assertions_inst (
    .clk_sys_in     (clk_sys_in),
    .rst_b_in       (rst_b_in),
    .instr_valid_in (instr_valid_in),
    .instr_in       (instr_in),
    .reg_rd_data_in (reg_rd_data_in),
    .reg_wr_out     (reg_wr_out),
    .acc_out        (acc_out),
    .flags_out      (flags_out),
    .done_out       (done_out)
);

// ### testbench/abod_regfile_model.sv
// Register file beside the datapath: combinational read, clocked write.
// Seeded with 80h OR address so every value is known.
`timescale 1ns/100ps
module abod_regfile_model (
    input  wire logic                   clk_sys_in,
    input  wire logic [6:0]             addr_in,
    input  wire abod_pkg::abod_reg_wr_s wr_in,
    output logic [7:0]                  rd_data_out
);
    import abod_pkg::*;
    logic [7:0] mem [128];
    assign rd_data_out = mem[addr_in];
    // One process seeds and writes, so the array has a single driver
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'h80 | 8'(i);
        forever @(posedge clk_sys_in) if (wr_in.wr_en) mem[wr_in.addr] <= wr_in.data;
    end
endmodule

// ### testbench/tb_abod_datapath.sv
// Self-checking bench for the add and bit-op datapath.
// Assumes the register file model answers reads in the same cycle.
`timescale 1ns/100ps
module tb_abod_datapath;
    import abod_pkg::*;
    logic         clk_sys_in = 1'b0;
    logic         rst_b_in = 1'b0;
    logic         instr_valid_in = 1'b0;
    abod_instr_s  instr_in = '0;
    logic [7:0]   reg_rd_data_in, acc_out, e;
    abod_reg_wr_s reg_wr_out;
    abod_flags_s  flags_out;
    logic         done_out;
    int           bad_count = 0;
    int           samples_checked = 0;
    abod_datapath abod_datapath_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .reg_rd_data_in(reg_rd_data_in), .reg_wr_out(reg_wr_out), .acc_out(acc_out),
        .flags_out(flags_out), .done_out(done_out));
    abod_regfile_model abod_regfile_model_inst (.clk_sys_in(clk_sys_in), .addr_in(instr_in.reg_addr),
        .wr_in(reg_wr_out), .rd_data_out(reg_rd_data_in));
    initial forever #2 clk_sys_in = ~clk_sys_in;
    task chk(input logic [7:0] g, input logic [7:0] x);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task run(input abod_op_e o, input logic [7:0] l, input logic [6:0] a, input logic d, input logic [2:0] i);
        @(posedge clk_sys_in);
        instr_in <= '{o, l, a, d, i};
        instr_valid_in <= 1'b1;
        @(posedge clk_sys_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    task t_add;
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'hff, 7'h0, 1'b1, 3'h0);
        chk(acc_out, 8'hff);
        chk({7'h0, done_out}, 8'h01);
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h0, 1'b1, 3'h0);
        chk({4'h0, flags_out, acc_out[0]}, 8'h0e);
        run(ABOD_OP_ADD_ACC_TO_REG, 8'h0, 7'h7f, DEST_REG, 3'h0);
        chk({reg_wr_out.wr_en, reg_wr_out.addr}, 8'hff);
        chk(reg_wr_out.data, 8'hff);
        run(ABOD_OP_ADD_ACC_TO_REG, 8'h0, 7'h01, DEST_ACC, 3'h0);
        chk(acc_out, 8'h81);
        run(ABOD_OP_ADD_ACC_TO_REG, 8'h0, 7'h7f, DEST_ACC, 3'h0);
        chk({5'h0, flags_out}, 8'h03);
    endtask
    task t_and;
        run(ABOD_OP_AND_ACC_WITH_REG, 8'h0, 7'h00, DEST_REG, 3'h0);
        chk(reg_wr_out.data, 8'h80);
        run(ABOD_OP_AND_LITERAL_WITH_ACC, 8'h7f, 7'h0, 1'b1, 3'h0);
        chk({5'h0, flags_out}, 8'h07);
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'h45, 7'h0, 1'b0, 3'h0);
        run(ABOD_OP_AND_ACC_WITH_REG, 8'h0, 7'h07, DEST_ACC, 3'h0);
        chk(acc_out, 8'h05);
        chk({7'h0, reg_wr_out.wr_en}, 8'h00);
        chk({5'h0, flags_out}, 8'h00);
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'hfb, 7'h0, 1'b0, 3'h0);
        chk({5'h0, flags_out}, 8'h07);
    endtask
    task t_bits;
        e = 8'hff;
        for (int i = 0; i < 16; i++) begin
            e[i % 8] = i > 7;
            run(i > 7 ? ABOD_OP_BIT_SET_IN_REG : ABOD_OP_BIT_CLEAR_IN_REG, 8'h0, 7'h7f, 1'b0, 3'(i % 8));
            chk(reg_wr_out.data, e);
        end
        chk({5'h0, flags_out}, 8'h07);
    endtask
    task t_b2b;
        @(posedge clk_sys_in);
        instr_in <= '{ABOD_OP_ADD_LITERAL_TO_ACC, 8'h10, 7'h0, 1'b0, 3'h0};
        instr_valid_in <= 1'b1;
        @(posedge clk_sys_in);
        instr_in.literal <= 8'h20;
        @(posedge clk_sys_in);
        instr_in.op <= ABOD_OP_NONE;
        @(posedge clk_sys_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({done_out, acc_out[6:0]}, 8'h30);
    endtask
    task t_rst;
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'hdf, 7'h0, 1'b0, 3'h0);
        chk({4'h0, flags_out, done_out}, 8'h03);
        @(posedge clk_sys_in);
        rst_b_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        chk(acc_out, ACC_RST);
        chk({4'h0, flags_out, done_out}, {4'h0, FLAG_RST, 1'b0});
        @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        run(ABOD_OP_ADD_LITERAL_TO_ACC, 8'h01, 7'h0, 1'b0, 3'h0);
        chk(acc_out, 8'h01);
    endtask
    task results;
        $display("checked=%0d bad=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        t_add;
        t_and;
        t_bits;
        t_b2b;
        t_rst;
        results;
    end
    initial begin
        #20000;
        bad_count++;
        results;
    end
endmodule

// ### verilog/abod_adder.sv
// Eight-bit adder split into nibbles for carry and half-carry outputs.
// Purely combinational; the datapath registers its results.
`timescale 1ns/100ps
module abod_adder (
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    output logic      [7:0] sum_out,
    output logic            carry_out,
    output logic            half_carry_out
);
    logic [4:0] low_nib;
    logic [4:0] high_nib;

    always_comb begin
        low_nib        = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        high_nib       = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low_nib[4]};
        sum_out        = {high_nib[3:0], low_nib[3:0]};
        half_carry_out = low_nib[4];
        carry_out      = high_nib[4];
    end
endmodule

// ### verilog/abod_datapath.sv
// Execution datapath for add, AND, bit clear and bit set instructions.
// Assumes the decoder presents one instruction per cycle with the addressed
// register's value already read from the register file on reg_rd_data_in.
//
// Functional notes
// - Literal add: acc plus 8-bit literal into acc; carry, half-carry, zero updated.
// - Register add: acc plus addressed register; carry, half-carry, zero updated.
// - Destination select zero writes acc; one writes back to addressed register.
// - Register AND: acc AND register to chosen destination; only zero changes.
// - Literal AND: acc AND literal into acc; only zero flag changes.
// - Bit clear: selected bit of addressed register forced low; flags untouched.
// - Bit set: selected bit of addressed register forced high; flags untouched.
`timescale 1ns/100ps
module abod_datapath (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  instr_valid_in,
    input  wire abod_pkg::abod_instr_s instr_in,
    input  wire logic [7:0]            reg_rd_data_in,
    output abod_pkg::abod_reg_wr_s     reg_wr_out,
    output logic [7:0]                 acc_out,
    output abod_pkg::abod_flags_s      flags_out,
    output logic                       done_out
);
    import abod_pkg::*;

    // Accumulator
    logic [7:0]   acc_reg;
    logic [7:0]   acc_next;

    // Flags, merged into the status register by the partner
    abod_flags_s  flags_reg;
    abod_flags_s  flags_next;

    // Register write-back
    abod_reg_wr_s wr_reg;
    abod_reg_wr_s wr_next;

    // Completion pulse
    logic         done_reg;
    logic         done_next;

    // Decode
    logic         exec;
    logic         is_add;
    logic         is_and;
    logic         is_bit;
    logic         to_reg;

    // Operands and results
    logic [7:0]   add_b;
    logic [7:0]   add_sum;
    logic         add_carry;
    logic         add_half;
    logic [7:0]   and_b;
    logic [7:0]   and_res;
    logic [7:0]   bit_mask;
    logic [7:0]   bit_res;
    logic [7:0]   result;
    logic         result_zero;

    // One class per instruction family
    always_comb begin
        is_add = 1'b0;
        is_and = 1'b0;
        is_bit = 1'b0;
        to_reg = 1'b0;
        unique case (instr_in.op)
            ABOD_OP_NONE: begin
                to_reg = 1'b0;
            end
            ABOD_OP_ADD_LITERAL_TO_ACC: begin
                is_add = 1'b1;
            end
            ABOD_OP_ADD_ACC_TO_REG: begin
                is_add = 1'b1;
                to_reg = (instr_in.dest_sel == DEST_REG);
            end
            ABOD_OP_AND_ACC_WITH_REG: begin
                is_and = 1'b1;
                to_reg = (instr_in.dest_sel == DEST_REG);
            end
            ABOD_OP_AND_LITERAL_WITH_ACC: begin
                is_and = 1'b1;
            end
            ABOD_OP_BIT_CLEAR_IN_REG: begin
                is_bit = 1'b1;
                to_reg = 1'b1;
            end
            ABOD_OP_BIT_SET_IN_REG: begin
                is_bit = 1'b1;
                to_reg = 1'b1;
            end
            // Spare code runs as no instruction rather than clearing acc
            default: begin
                to_reg = 1'b0;
            end
        endcase
        exec = instr_valid_in && (is_add || is_and || is_bit);
    end

    // Literal ops take the immediate, the rest the register read
    always_comb begin
        if (instr_in.op == ABOD_OP_ADD_LITERAL_TO_ACC) begin
            add_b = instr_in.literal;
        end else begin
            add_b = reg_rd_data_in;
        end
        if (instr_in.op == ABOD_OP_AND_LITERAL_WITH_ACC) begin
            and_b = instr_in.literal;
        end else begin
            and_b = reg_rd_data_in;
        end
        bit_mask = 8'h01 << instr_in.bit_idx;
    end

    // Shared adder: literal or register operand, never both
    abod_adder u_adder (
        .a_in           (acc_reg),
        .b_in           (add_b),
        .sum_out        (add_sum),
        .carry_out      (add_carry),
        .half_carry_out (add_half)
    );

    // Zero test sees the value actually delivered
    always_comb begin
        and_res = acc_reg & and_b;
        if (instr_in.op == ABOD_OP_BIT_SET_IN_REG) begin
            bit_res = reg_rd_data_in | bit_mask;
        end else begin
            bit_res = reg_rd_data_in & ~bit_mask;
        end
        if (is_add) begin
            result = add_sum;
        end else if (is_and) begin
            result = and_res;
        end else if (is_bit) begin
            result = bit_res;
        end else begin
            result = DATA_ZERO;
        end
        result_zero = (result == DATA_ZERO);
    end

    // Accumulator takes only results aimed at it
    always_comb begin
        acc_next = acc_reg;
        if (exec && !to_reg) begin
            acc_next = result;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_reg <= ACC_RST;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // Bit ops leave all flags alone, AND touches only zero
    always_comb begin
        flags_next = flags_reg;
        if (exec && !is_bit) begin
            flags_next.zero = result_zero;
        end
        if (exec && is_add) begin
            flags_next.carry           = add_carry;
            flags_next.half_carry_flag = add_half;
        end
    end

    // Reset clears flags so no stale carry reaches the partner
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_reg <= FLAG_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Address follows the instruction even when nothing is written
    always_comb begin
        wr_next      = '0;
        wr_next.addr = instr_in.reg_addr;
        if (exec && to_reg) begin
            wr_next.wr_en = 1'b1;
            wr_next.data  = result;
        end
    end

    // Write strobe lasts one cycle; forwarding is the partner's job
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_reg <= '0;
        end else begin
            wr_reg <= wr_next;
        end
    end

    // One pulse for each executed instruction
    always_comb begin
        done_next = exec;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    // Outputs come straight from the registers
    assign acc_out    = acc_reg;
    assign flags_out  = flags_reg;
    assign reg_wr_out = wr_reg;
    assign done_out   = done_reg;
endmodule

// ### verilog/abod_pkg.sv
// Package for the add and bit-op datapath: opcodes, widths, flag layout.
// Assumes a single core clock domain; no bus, all controls are ports.
package abod_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned BIT_IDX_W = 3;
    localparam int unsigned HALF_MSB  = 3;
    localparam int unsigned CARRY_POS = 0;
    localparam int unsigned HALF_POS  = 1;
    localparam int unsigned ZERO_POS  = 2;
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [2:0]  FLAG_RST  = 3'h0;
    localparam logic [7:0]  DATA_ZERO = 8'h00;
    localparam logic        DEST_ACC  = 1'b0;
    localparam logic        DEST_REG  = 1'b1;

    typedef enum logic [2:0] {
        ABOD_OP_NONE,
        ABOD_OP_ADD_LITERAL_TO_ACC,
        ABOD_OP_ADD_ACC_TO_REG,
        ABOD_OP_AND_ACC_WITH_REG,
        ABOD_OP_AND_LITERAL_WITH_ACC,
        ABOD_OP_BIT_CLEAR_IN_REG,
        ABOD_OP_BIT_SET_IN_REG
    } abod_op_e;

    typedef struct packed {
        abod_op_e         op;
        logic [7:0]       literal;
        logic [6:0]       reg_addr;
        logic             dest_sel;
        logic [2:0]       bit_idx;
    } abod_instr_s;

    typedef struct packed {
        logic             zero;
        logic             half_carry_flag;
        logic             carry;
    } abod_flags_s;

    typedef struct packed {
        logic             wr_en;
        logic [6:0]       addr;
        logic [7:0]       data;
    } abod_reg_wr_s;

endpackage
